// File: design/phy_irq_power_ctl.sv
// Per-PHY interrupt flags, power-down control and low-power-idle enable.
// Assumes register strobes arrive as one-cycle pulses from the management interface
// and status inputs are synchronous to clk.
//
// Notes on behaviour
// - Alternate flag handling only while alternate select is 1, else primary.
// - Each flag has an enable bit at the same position; only enabled ones interrupt.
// - Writing 1 in alternate mode rechecks the source instead of clearing blindly.
// - Recheck clears flag and interrupt if source idle, else both stay set.
// - Link-up source is an internal link status not shown in any register.
// - Wake source is OR of received-status bits ANDed with their enables.
// - Energy status and flag start at 1, clear after a few quiet milliseconds.
// - Every PHY instance keeps its own power-down state.
// - Power-down entry or exit never reloads or resets the registers.
// - General power-off bit keeps the transceiver down; management stays live.
// - Clearing the power-off bit powers up and resets the transceiver.
// - Sleep enable with no energy powers down all but management and detection.
// - While asleep and energy low, stay down and transmit no data.
// - Energy returning wakes, restores prior state and sets the energy flag.
// - Asleep, send link pulses only if enabled, at the selected interval.
// - Wake on one pulse if enabled, else two pulses within selected window.
// - Wake enable bit 14 serves the first PHY, bit 15 the second.
// - Low-power-idle enable takes a strap just after reset and switches the function.
// - Low-power idle runs only with enable, advert, MAC and peer support and 100 full.
// - The enable sets defaults of the capability and advertisement bits.
// - After reset primary mode holds; reading the flag register clears flags.
// - All enabled set flags are ORed into one interrupt output.
`timescale 1ns/1ps
module phy_irq_power_ctl #(
   parameter int PHY_INDEX = 0, // 0 first PHY, 1 second PHY
   parameter int ENERGY_QUIET_CYC = phy_mgmt_pkg::ENERGY_QUIET_CYC,
   parameter int NLP_TX_STEP_CYC = phy_mgmt_pkg::NLP_TX_STEP_CYC,
   parameter int NLP_RX_STEP_CYC = phy_mgmt_pkg::NLP_RX_STEP_CYC
) (
   input wire logic clk, // Management clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic alternate_irq_select, // Mode control bit
   input wire logic [9:1] phy_irq_enable_reg, // Interrupt enable bits
   input wire logic flag_wr, // Write strobe to flag register
   input wire logic [9:1] flag_wdata, // Write data to flag register
   input wire logic flag_rd, // Read strobe of flag register
   input wire logic basic_stat_rd, // Read strobe of basic status register
   input wire logic an_exp_rd, // Read strobe of negotiation expansion register
   input wire logic an_restart, // Negotiation restart pulse
   input wire logic internal_link_up, // Internal link status
   input wire logic [7:0] wake_ctl_stat_reg, // Wake received bits and enables
   input wire logic an_complete, // Negotiation complete status
   input wire logic remote_fault, // Remote fault status
   input wire logic link_status, // Register link status
   input wire logic lp_ack, // Partner acknowledge
   input wire logic par_fault, // Parallel detection fault
   input wire logic page_rx, // Page received
   input wire logic general_power_off_bit, // Basic control power-down bit
   input wire logic energy_detect_sleep_enable, // Energy detect sleep enable
   input wire logic nlp_tx_enable, // Send link pulses while asleep
   input wire logic [1:0] nlp_tx_sel, // Transmit pulse interval select
   input wire logic single_nlp_wake, // Wake on a single pulse
   input wire logic [1:0] nlp_rx_sel, // Two-pulse window select
   input wire logic [15:14] power_mgmt_ctl_reg, // Energy wake enables
   input wire logic line_noise_gate, // Line_noise_gate sees line energy
   input wire logic rx_link_pulse, // Received link pulse
   input wire logic rx_packet_energy, // Packet energy on the line
   input wire logic lpi_default_strap_a, // Low-power-idle strap
   input wire logic lpi_enable_wr, // Write strobe of the enable bit
   input wire logic lpi_enable_wdata, // Write data of the enable bit
   input wire logic lpi_adv_100tx, // 100 Mb/s advertisement bit
   input wire logic mac_lpi_ok, // MAC supports low-power idle
   input wire logic partner_lpi_ok, // Partner supports low-power idle
   input wire logic link_100_full, // Link is 100 Mb/s full duplex
   output logic [9:1] phy_irq_flag_reg, // Flag register value
   output logic phy_irq, // Internal interrupt
   output logic line_energy_present, // Energy status
   output logic xcvr_power_on, // Transceiver powered
   output logic xcvr_reset, // Transceiver reset pulse
   output logic xcvr_restore, // Restore prior state pulse
   output logic tx_allowed, // Transmitter may send data
   output logic nlp_tx_pulse, // Send one link pulse
   output logic energy_wake_req, // Wake request toward power management
   output logic low_power_idle_enable, // Enable bit value
   output logic lpi_cap_default, // Capability bit default
   output logic lpi_adv_default, // Advertisement bit default
   output logic lpi_active // Low-power idle may operate
);
   phy_mgmt_pkg::pwr_state_t state_ff, nxt_state;
   logic [9:1] flags_ff;
   logic [9:1] nxt_flags;
   logic [9:1] prev_ff;
   logic [9:1] src;
   logic [9:1] active;
   logic [9:1] rise;
   logic [9:1] clr;
   logic [9:1] keep_mask;
   logic wake_event_source;
   logic energy_ff;
   logic [31:0] quiet_ff;
   logic restore_ff;
   logic lpi_en_ff;
   logic strap_taken_ff;
   logic sleeping;
   logic nlp_wake;
   logic nlp_tick;
   logic energy_seen;
   logic exp_clr_event;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Wake source: received bits gated by their enables, then ORed
   assign wake_event_source = |(wake_ctl_stat_reg[7:4] & wake_ctl_stat_reg[3:0]);

   // Source vector, link-up taken from internal status only
   assign src[phy_mgmt_pkg::FLAG_LINK_UP] = internal_link_up;
   assign src[phy_mgmt_pkg::FLAG_WAKE] = wake_event_source;
   assign src[phy_mgmt_pkg::FLAG_ENERGY] = energy_ff;
   assign src[phy_mgmt_pkg::FLAG_AN_DONE] = an_complete;
   assign src[phy_mgmt_pkg::FLAG_REM_FAULT] = remote_fault;
   assign src[phy_mgmt_pkg::FLAG_LINK_DOWN] = link_status;
   assign src[phy_mgmt_pkg::FLAG_LP_ACK] = lp_ack;
   assign src[phy_mgmt_pkg::FLAG_PAR_FAULT] = par_fault;
   assign src[phy_mgmt_pkg::FLAG_PAGE_RX] = page_rx;

   // Link down also acts as a clear event for the negotiation flags
   assign exp_clr_event = an_exp_rd || an_restart || !link_status;

   // Per-flag set and clear terms; link-down flag asserts on a falling source
   for (genvar i = 1; i <= 9; i++) begin : g_flag
      assign active[i] = src[i] ^ phy_mgmt_pkg::LOW_ACTIVE[i];
      assign rise[i] = active[i] && !prev_ff[i];
      // Alternate: a 1 written only clears once the source is idle
      // Primary: register read, source return (not for the link-down flag) or the listed side events
      assign clr[i] = alternate_irq_select ?
         (flag_wr && flag_wdata[i] && !active[i]) :
         (flag_rd
          || (!active[i] && !phy_mgmt_pkg::LOW_ACTIVE[i])
          || (basic_stat_rd && phy_mgmt_pkg::STAT_RD_CLR[i])
          || (exp_clr_event && phy_mgmt_pkg::EXP_RD_CLR[i]));
      // A new edge in the clearing cycle still sets the flag
      assign nxt_flags[i] = rise[i] || (flags_ff[i] && !clr[i]);
   end

   // Flag and edge history registers; energy flag starts set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_ff <= phy_mgmt_pkg::FLAG_RST;
         prev_ff <= phy_mgmt_pkg::PREV_RST;
      end else begin
         flags_ff <= nxt_flags;
         prev_ff <= active;
      end
   end

   assign phy_irq_flag_reg = flags_ff;
   // Only enabled flags reach the single interrupt line
   assign phy_irq = |(flags_ff & phy_irq_enable_reg);

   // Energy is seen directly while awake; asleep it needs a qualified pulse wake or packet energy
   assign sleeping = (state_ff == phy_mgmt_pkg::PWR_SLEEP);
   assign energy_seen = sleeping ? (nlp_wake || rx_packet_energy)
                                 : (line_noise_gate || rx_packet_energy);

   // Energy status: set on energy, dropped after a quiet stretch
   // Starts high so acquisition begins as if energy were present
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         energy_ff <= phy_mgmt_pkg::ENERGY_RST;
         quiet_ff <= 32'h0;
      end else if (energy_seen) begin
         energy_ff <= 1'b1;
         quiet_ff <= 32'h0;
      end else if (quiet_ff >= 32'(ENERGY_QUIET_CYC - 1)) begin
         energy_ff <= 1'b0;
         quiet_ff <= quiet_ff;
      end else begin
         quiet_ff <= quiet_ff + 32'h1;
      end
   end

   assign line_energy_present = energy_ff;

   // Power state choice; register values are never touched here
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         phy_mgmt_pkg::PWR_ON: begin
            if (general_power_off_bit)
               nxt_state = phy_mgmt_pkg::PWR_OFF;
            else if (energy_detect_sleep_enable && !energy_ff)
               nxt_state = phy_mgmt_pkg::PWR_SLEEP;
         end
         phy_mgmt_pkg::PWR_OFF: begin
            if (!general_power_off_bit)
               nxt_state = phy_mgmt_pkg::PWR_RESTART;
         end
         phy_mgmt_pkg::PWR_SLEEP: begin
            if (general_power_off_bit)
               nxt_state = phy_mgmt_pkg::PWR_OFF;
            else if (!energy_detect_sleep_enable || energy_ff)
               nxt_state = phy_mgmt_pkg::PWR_ON;
         end
         phy_mgmt_pkg::PWR_RESTART: begin
            nxt_state = general_power_off_bit ? phy_mgmt_pkg::PWR_OFF : phy_mgmt_pkg::PWR_ON;
         end
         default: nxt_state = phy_mgmt_pkg::PWR_ON;
      endcase
   end

   // State and the one-cycle restore pulse on leaving sleep for PWR_ON
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= phy_mgmt_pkg::PWR_ON;
         restore_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         restore_ff <= sleeping && (nxt_state == phy_mgmt_pkg::PWR_ON);
      end
   end

   // Power outputs decoded from the registered state; restore comes from its own pulse register
   assign xcvr_power_on = (state_ff == phy_mgmt_pkg::PWR_ON)
                          || (state_ff == phy_mgmt_pkg::PWR_RESTART);
   assign xcvr_reset = (state_ff == phy_mgmt_pkg::PWR_RESTART);
   assign xcvr_restore = restore_ff;
   assign tx_allowed = (state_ff == phy_mgmt_pkg::PWR_ON);

   // Link pulses while asleep only when enabled; data path stays silent
   nlp_tx_timer #(
      .STEP_CYC(NLP_TX_STEP_CYC)
   ) u_tx_timer (
      .clk(clk),
      .rst_n(rst_n),
      .run(sleeping && nlp_tx_enable),
      .sel(nlp_tx_sel),
      .tick(nlp_tick)
   );
   assign nlp_tx_pulse = nlp_tick && sleeping && nlp_tx_enable;

   // One or two pulses, armed only in sleep so stray pulses cost nothing
   nlp_wake_detect #(
      .STEP_CYC(NLP_RX_STEP_CYC)
   ) u_wake_detect (
      .clk(clk),
      .rst_n(rst_n),
      .armed(sleeping),
      .single_en(single_nlp_wake),
      .sel(nlp_rx_sel),
      .rx_pulse(rx_link_pulse),
      .wake(nlp_wake)
   );

   // Wake request routed by this PHY's own enable bit
   assign energy_wake_req = restore_ff && ((PHY_INDEX == 0) ?
      power_mgmt_ctl_reg[phy_mgmt_pkg::PM_ED_WAKE_A] :
      power_mgmt_ctl_reg[phy_mgmt_pkg::PM_ED_WAKE_B]);

   // Enable bit takes the strap in the first cycle after reset release;
   // caught by a clocked step so reset itself loads only a constant
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lpi_en_ff <= 1'b0;
         strap_taken_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         lpi_en_ff <= lpi_default_strap_a;
         strap_taken_ff <= 1'b1;
      end else if (lpi_enable_wr) begin
         lpi_en_ff <= lpi_enable_wdata;
      end
   end

   assign low_power_idle_enable = lpi_en_ff;
   assign lpi_cap_default = lpi_en_ff;
   assign lpi_adv_default = lpi_en_ff;
   assign lpi_active = lpi_en_ff && lpi_adv_100tx && mac_lpi_ok
                       && partner_lpi_ok && link_100_full;

   // Checks

   // Flags that a recheck must leave set: raised while their source is still active
   assign keep_mask = flags_ff & active;

   a_alt_keep_flag: assert property (
      alternate_irq_select && flag_wr
      |=> (flags_ff & $past(keep_mask)) == $past(keep_mask))
      else $error("flag cleared while source still active");

   a_alt_clear_flag: assert property (
      alternate_irq_select && flag_wr && flag_wdata[6] && !an_complete
      |=> !flags_ff[6])
      else $error("recheck did not clear idle flag");

   a_pri_read_clear: assert property (
      !alternate_irq_select && flag_rd && !(|rise) |=> flags_ff == 9'h000)
      else $error("primary read did not clear flags");

   a_irq_from_flag: assert property (
      $rose(flags_ff[9]) && phy_irq_enable_reg[9] |-> phy_irq)
      else $error("enabled flag did not raise interrupt");

   a_wake_sets_flag: assert property (
      $rose(wake_event_source) |=> flags_ff[8])
      else $error("wake source edge lost");

   a_energy_sets_flag: assert property (
      $rose(energy_ff) |=> flags_ff[7])
      else $error("energy edge did not set flag");

   a_general_off: assert property (
      general_power_off_bit |=> !xcvr_power_on && !tx_allowed)
      else $error("transceiver powered during power-off");

   a_restart_pulse: assert property (
      state_ff == phy_mgmt_pkg::PWR_OFF && !general_power_off_bit
      |=> xcvr_reset ##1 !xcvr_reset)
      else $error("no single reset pulse on power-up");

   a_sleep_entry: assert property (
      state_ff == phy_mgmt_pkg::PWR_ON && energy_detect_sleep_enable
      && !general_power_off_bit && !energy_ff |=> !xcvr_power_on ##0 !tx_allowed)
      else $error("did not sleep without energy");

   a_sleep_wake: assert property (
      sleeping && energy_detect_sleep_enable && !general_power_off_bit && energy_ff
      |=> xcvr_restore && xcvr_power_on)
      else $error("no wake on energy");

   a_lpi_gate: assert property (
      lpi_active |-> lpi_en_ff && lpi_adv_100tx && link_100_full)
      else $error("low-power idle active without conditions");

   a_no_tx_asleep: assert property (
      sleeping |-> !xcvr_power_on && !tx_allowed)
      else $error("transceiver live while asleep");

   a_pulse_gate: assert property (
      !(sleeping && nlp_tx_enable) |-> !nlp_tx_pulse)
      else $error("link pulse sent outside enabled sleep");

   a_single_wake: assert property (
      sleeping && single_nlp_wake && rx_link_pulse && energy_detect_sleep_enable
      && !general_power_off_bit && !energy_ff |=> nlp_wake ##1 energy_ff)
      else $error("single pulse did not wake");

   a_wake_route: assert property (
      xcvr_restore |-> energy_wake_req == power_mgmt_ctl_reg[(PHY_INDEX == 0) ?
         phy_mgmt_pkg::PM_ED_WAKE_A : phy_mgmt_pkg::PM_ED_WAKE_B])
      else $error("wake request not routed by own enable");

endmodule // phy_irq_power_ctl

// File: design/phy_mgmt_pkg.sv
// Shared constants for the per-PHY interrupt, power-down and low-power-idle logic.
// Assumes a single 25 MHz management clock; all times are converted here.
package phy_mgmt_pkg;

   // Clock rate
   localparam int CLK_KHZ = 25000;

   // Energy status drops after this much quiet line (longest time, rounds down)
   localparam int ENERGY_QUIET_US = 2000;
   localparam int ENERGY_QUIET_CYC = ENERGY_QUIET_US * CLK_KHZ / 1000;

   // Transmit link-pulse interval step while asleep; interval is step * (select + 1)
   localparam int NLP_TX_STEP_MS = 256;
   localparam int NLP_TX_STEP_CYC = NLP_TX_STEP_MS * CLK_KHZ;

   // Two-pulse wake window step; window is step * (select + 1)
   localparam int NLP_RX_STEP_MS = 16;
   localparam int NLP_RX_STEP_CYC = NLP_RX_STEP_MS * CLK_KHZ;

   // Interrupt flag positions inside the flag and enable registers
   localparam int FLAG_LINK_UP = 9;
   localparam int FLAG_WAKE = 8;
   localparam int FLAG_ENERGY = 7;
   localparam int FLAG_AN_DONE = 6;
   localparam int FLAG_REM_FAULT = 5;
   localparam int FLAG_LINK_DOWN = 4;
   localparam int FLAG_LP_ACK = 3;
   localparam int FLAG_PAR_FAULT = 2;
   localparam int FLAG_PAGE_RX = 1;

   // Flag reset value: energy flag reads 1 at power-up
   localparam logic [9:1] FLAG_RST = 9'h040;
   // Sources whose assert event is a falling edge
   localparam logic [9:1] LOW_ACTIVE = 9'h008;
   // Edge-detector history reset, matches the reset levels of the sources
   localparam logic [9:1] PREV_RST = 9'h048;
   // Flags also cleared in primary mode by a read of the status register
   localparam logic [9:1] STAT_RD_CLR = 9'h018;
   // Flags also cleared in primary mode by an expansion read, renegotiation or link down
   localparam logic [9:1] EXP_RD_CLR = 9'h003;

   // Energy status value at start of signal acquisition
   localparam logic ENERGY_RST = 1'b1;

   // Energy-detect wake enable positions in the power management control register
   localparam int PM_ED_WAKE_A = 14;
   localparam int PM_ED_WAKE_B = 15;

   // Transceiver power states
   typedef enum logic [1:0] {PWR_ON, PWR_OFF, PWR_SLEEP, PWR_RESTART} pwr_state_t;

endpackage

// File: design/nlp_tx_timer.sv
// Periodic tick for link pulses sent while the transceiver sleeps.
// Assumes run is held for as long as pulses are wanted; counter restarts on run low.
`timescale 1ns/1ps
module nlp_tx_timer #(
   parameter int STEP_CYC = phy_mgmt_pkg::NLP_TX_STEP_CYC
) (
   input wire logic clk, // Management clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic run, // Count while high
   input wire logic [1:0] sel, // Interval select
   output logic tick // One-cycle pulse per interval
);
   logic [31:0] cnt_ff;
   logic [31:0] limit;

   // Interval length in cycles minus one
   assign limit = 32'(STEP_CYC * (int'(sel) + 1) - 1);

   // Free count, cleared whenever not running
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         cnt_ff <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_ff >= limit) begin
         cnt_ff <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // nlp_tx_timer

// File: design/nlp_wake_detect.sv
// Decides when received link pulses should wake the sleeping transceiver.
// Assumes rx_pulse is one cycle per received pulse; armed is high only while asleep.
`timescale 1ns/1ps
module nlp_wake_detect #(
   parameter int STEP_CYC = phy_mgmt_pkg::NLP_RX_STEP_CYC
) (
   input wire logic clk, // Management clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic armed, // Sleeping, detector live
   input wire logic single_en, // Wake on one pulse
   input wire logic [1:0] sel, // Two-pulse window select
   input wire logic rx_pulse, // Received link pulse
   output logic wake // One-cycle wake pulse
);
   logic [31:0] cnt_ff;
   logic open_ff;
   logic [31:0] limit;

   // Window length in cycles minus one
   assign limit = 32'(STEP_CYC * (int'(sel) + 1) - 1);

   // A first pulse opens the window; a second inside it wakes
   always_ff @(posedge clk) begin
      if (!rst_n || !armed) begin
         cnt_ff <= 32'h0;
         open_ff <= 1'b0;
         wake <= 1'b0;
      end else if (rx_pulse) begin
         wake <= single_en || open_ff;
         open_ff <= !(single_en || open_ff);
         cnt_ff <= 32'h0;
      end else begin
         wake <= 1'b0;
         open_ff <= open_ff && (cnt_ff < limit);
         cnt_ff <= open_ff ? cnt_ff + 32'h1 : 32'h0;
      end
   end
endmodule // nlp_wake_detect

// File: testbench/line_peer.sv
// Link partner on the far side of the line: link pulses and packet energy.
// Assumes requests come from the bench, one cycle high per pulse wanted.
`timescale 1ns/1ps
module line_peer (
   input wire logic clk, // Management clock
   input wire logic pulse_req, // Send one link pulse
   input wire logic burst_req, // Hold packet energy on the line
   output logic rx_link_pulse, // Received link pulse
   output logic rx_packet_energy // Packet energy level
);
   // Registered so the line changes only just after an edge
   always_ff @(posedge clk) begin
      rx_link_pulse <= pulse_req;
      rx_packet_energy <= burst_req;
   end
endmodule // line_peer

// File: testbench/tb.sv
// Self-checking bench for the per-PHY interrupt and power-down block.
// Assumes short timer parameters; inputs change on the falling edge only.
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, rst_n = 1'b0, alt_sel = 1'b0, flag_wr = 1'b0, flag_rd = 1'b0;
   logic [9:1] irq_en = 9'h000, wdata = 9'h000, src = 9'h000, flag_reg;
   logic link_status = 1'b1, off = 1'b0, sleep_en = 1'b0, pulse_req = 1'b0;
   logic [7:0] wake_ctl = 8'h00;
   logic [15:14] pm = 2'b00;
   logic lpi_wr = 1'b0, lpi_wd = 1'b0, lpi_ok = 1'b1, full100 = 1'b1, adv = 1'b1, mac_ok = 1'b1;
   logic burst = 1'b0, stat_rd = 1'b0, exp_rd = 1'b0, tx_en = 1'b1, single = 1'b0;
   logic phy_irq, energy, pwr_on, xreset, restore, tx_ok, nlp_tx, wake_req;
   logic lpi_en, cap_def, adv_def, lpi_act, rx_pulse, rx_energy;
   int bad_count = 0;
   int tests_run = 0;

   // Free-running management clock
   always #20 clk = ~clk;

   line_peer peer (.clk(clk), .pulse_req(pulse_req), .burst_req(burst),
      .rx_link_pulse(rx_pulse), .rx_packet_energy(rx_energy));

   phy_irq_power_ctl #(.PHY_INDEX(0), .ENERGY_QUIET_CYC(20), .NLP_TX_STEP_CYC(10),
      .NLP_RX_STEP_CYC(10)) dut (
      .clk(clk), .rst_n(rst_n), .alternate_irq_select(alt_sel), .phy_irq_enable_reg(irq_en),
      .flag_wr(flag_wr), .flag_wdata(wdata), .flag_rd(flag_rd), .basic_stat_rd(stat_rd),
      .an_exp_rd(exp_rd), .an_restart(1'b0), .internal_link_up(src[9]),
      .wake_ctl_stat_reg(wake_ctl), .an_complete(src[6]), .remote_fault(src[5]),
      .link_status(link_status), .lp_ack(src[3]), .par_fault(src[2]), .page_rx(src[1]),
      .general_power_off_bit(off), .energy_detect_sleep_enable(sleep_en),
      .nlp_tx_enable(tx_en), .nlp_tx_sel(2'b00), .single_nlp_wake(single),
      .nlp_rx_sel(2'b00), .power_mgmt_ctl_reg(pm), .line_noise_gate(1'b0),
      .rx_link_pulse(rx_pulse), .rx_packet_energy(rx_energy), .lpi_default_strap_a(1'b1),
      .lpi_enable_wr(lpi_wr), .lpi_enable_wdata(lpi_wd), .lpi_adv_100tx(adv),
      .mac_lpi_ok(mac_ok), .partner_lpi_ok(lpi_ok), .link_100_full(full100),
      .phy_irq_flag_reg(flag_reg), .phy_irq(phy_irq), .line_energy_present(energy),
      .xcvr_power_on(pwr_on), .xcvr_reset(xreset), .xcvr_restore(restore),
      .tx_allowed(tx_ok), .nlp_tx_pulse(nlp_tx), .energy_wake_req(wake_req),
      .low_power_idle_enable(lpi_en), .lpi_cap_default(cap_def),
      .lpi_adv_default(adv_def), .lpi_active(lpi_act));

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe; result is settled by the following falling edge
   task automatic wr_flag(input logic [9:1] v);
      flag_wr = 1'b1;
      wdata = v;
      step(1);
      flag_wr = 1'b0;
      step(1);
   endtask

   task automatic alt_sources();
      int idx[6] = '{9, 6, 5, 3, 2, 1};
      logic [9:1] one;
      alt_sel = 1'b1;
      foreach (idx[k]) begin
         one = 9'h001 << (idx[k] - 1);
         irq_en = one;
         src = src | one;
         step(3);
         check("flag set", flag_reg & one, one);
         check("irq raised", phy_irq, 1'b1);
         wr_flag(one);
         check("flag kept", flag_reg & one, one);
         src = src & ~one;
         step(2);
         check("flag kept alt", flag_reg & one, one);
         wr_flag(one);
         check("flag cleared", flag_reg & one, 9'h000);
         check("irq dropped", phy_irq, 1'b0);
      end
      irq_en = 9'h000;
      src[1] = 1'b1;
      step(3);
      check("masked irq", phy_irq, 1'b0);
      src[1] = 1'b0;
      step(1);
      wr_flag(9'h001);
   endtask

   task automatic primary_read();
      link_status = 1'b0;
      wake_ctl = 8'h22;
      step(3);
      check("link down flag", flag_reg[4], 1'b1);
      check("wake flag", flag_reg[8], 1'b1);
      alt_sel = 1'b0;
      flag_rd = 1'b1;
      step(1);
      flag_rd = 1'b0;
      step(1);
      check("read clears", flag_reg & 9'h088, 9'h000);
      link_status = 1'b1;
      wake_ctl = 8'h00;
      step(2);
      src = 9'h012;
      step(2);
      stat_rd = 1'b1;
      step(1);
      stat_rd = 1'b0;
      step(1);
      check("status read clears", flag_reg & 9'h012, 9'h002);
      exp_rd = 1'b1;
      step(1);
      exp_rd = 1'b0;
      step(1);
      check("expansion read clears", flag_reg & 9'h012, 9'h000);
      src = 9'h000;
   endtask

   task automatic power_cycle();
      int n = 0;
      off = 1'b1;
      step(2);
      check("general off", pwr_on, 1'b0);
      off = 1'b0;
      while (xreset !== 1'b1 && n < 5) begin
         step(1);
         n++;
      end
      check("restart pulse", xreset, 1'b1);
      step(1);
      check("powered", {xreset, pwr_on}, 2'b01);
      check("regs kept", lpi_en, 1'b1);
   endtask

   task automatic sleep_wake();
      int n = 0;
      sleep_en = 1'b1;
      pm = 2'b01;
      step(3);
      check("asleep", {pwr_on, tx_ok}, 2'b00);
      repeat (25) begin
         step(1);
         n += nlp_tx;
      end
      check("tx pulses", n >= 2, 1'b1);
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
      step(30);
      check("one pulse no wake", pwr_on, 1'b0);
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
      step(2);
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
      n = 0;
      while (restore !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      check("restore", {restore, pwr_on}, 2'b11);
      check("wake request", wake_req, 1'b1);
      step(2);
      check("energy flag", {energy, flag_reg[7]}, 2'b11);
      sleep_en = 1'b0;
      step(3);
   endtask

   // No pulses when disabled, single-pulse wake, then packet energy wake
   task automatic wake_variants();
      int n = 0;
      {tx_en, single, sleep_en} = 3'b011;
      step(40);
      repeat (25) begin
         step(1);
         n += nlp_tx;
      end
      check("tx pulses off", {pwr_on, n == 0}, 2'b01);
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
      step(4);
      check("single wake", pwr_on, 1'b1);
      step(30);
      check("asleep again", pwr_on, 1'b0);
      burst = 1'b1;
      step(4);
      check("packet wake", {pwr_on, energy}, 2'b11);
      {burst, single, sleep_en, tx_en} = 4'b0001;
      step(2);
   endtask

   task automatic lpi_write(input logic v);
      lpi_wr = 1'b1;
      lpi_wd = v;
      step(1);
      lpi_wr = 1'b0;
      step(1);
   endtask

   task automatic lpi_check();
      lpi_write(1'b0);
      check("lpi off", {lpi_en, cap_def, adv_def, lpi_act}, 4'h0);
      lpi_write(1'b1);
      check("lpi on", {lpi_en, lpi_act}, 2'b11);
      full100 = 1'b0;
      step(1);
      check("lpi half", lpi_act, 1'b0);
      full100 = 1'b1;
      {adv, mac_ok, lpi_ok} = 3'b011;
      step(1);
      check("lpi adv", lpi_act, 1'b0);
      {adv, mac_ok, lpi_ok} = 3'b101;
      step(1);
      check("lpi mac", lpi_act, 1'b0);
      {adv, mac_ok, lpi_ok} = 3'b110;
      step(1);
      check("lpi peer", lpi_act, 1'b0);
   endtask

   task automatic final_report();
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      step(5);
      check("reset flags", flag_reg, 9'h040);
      check("reset energy", {energy, pwr_on}, 2'b11);
      rst_n = 1'b1;
      step(2);
      check("strap", {lpi_en, cap_def, adv_def}, 3'b111);
      step(30);
      check("quiet", {energy, flag_reg[7]}, 2'b00);
      alt_sources();
      primary_read();
      power_cycle();
      sleep_wake();
      wake_variants();
      lpi_check();
      final_report();
   end

   // Watchdog well past the expected run length
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
endmodule // tb
